// >>> frp_defines.svh
// Timing figures and reset values for the fault response and power mode block.
// Assumes a single 125 MHz reference clock; times are given in microseconds.
`ifndef FRP_DEFINES_SVH
`define FRP_DEFINES_SVH

// ==========================================================================
// Clock
`define FRP_CLK_MHZ      125

// ==========================================================================
// Timing figures in microseconds
`define FRP_T_RST_US     20
`define FRP_T_SLEEP_US   100
`define FRP_T_WAKE_US    1000
`define FRP_T_RETRY_US   4000

// ==========================================================================
// Derived cycle counts; each is the time in microseconds times FRP_CLK_MHZ
`define FRP_RST_CYC      (`FRP_T_RST_US * `FRP_CLK_MHZ)
`define FRP_SLEEP_CYC    (`FRP_T_SLEEP_US * `FRP_CLK_MHZ)
`define FRP_WAKE_CYC     (`FRP_T_WAKE_US * `FRP_CLK_MHZ)
`define FRP_RETRY_CYC    (`FRP_T_RETRY_US * `FRP_CLK_MHZ)

// ==========================================================================
// Response select codes and reset values
`define FRP_OCR_LATCH    2'h0
`define FRP_OCR_RETRY    2'h1
`define FRP_OCR_REPORT   2'h2
`define FRP_OCR_OFF      2'h3
`define FRP_CNT_W        24
`define FRP_PIN_RST      9'h000

`endif

// >>> frp_pkg.sv
// Types shared by the fault response and power mode block.
// Assumes frp_defines.svh supplies widths.
`include "frp_defines.svh"

package frp_pkg;

    // ======================================================================
    // Power modes
    typedef enum logic [1:0] {
        FRP_SLEEP,
        FRP_WAKING,
        FRP_ACTIVE
    } frp_mode_e;

    typedef logic [`FRP_CNT_W-1:0] frp_cnt_t;

endpackage

// >>> frp_pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes inputs are asynchronous to ref_clk.
`timescale 1ns/1ns

module frp_pin_sync #(
    parameter int W = 9
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] val;
    } frp_sync_s;

    frp_sync_s st_q;
    frp_sync_s st_d;

    // ======================================================================
    // A level counts only once stages two and three agree.
    always_comb begin
        st_d     = st_q;
        st_d.s1  = pin_in;
        st_d.s2  = st_q.s1;
        st_d.s3  = st_q.s2;
        st_d.val = (~(st_q.s2 ^ st_q.s3) & st_q.s2) | ((st_q.s2 ^ st_q.s3) & st_q.val);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pin_out = st_q.val;

endmodule // frp_pin_sync

// >>> frp_enable_pulse.sv
// Classifies low periods of the enable pin as reset pulse or sleep request.
// Assumes en_s is already synchronised to ref_clk.
`timescale 1ns/1ns

module frp_enable_pulse
    import frp_pkg::*;
#(
    parameter int unsigned RST_CYC   = 2500,
    parameter int unsigned SLEEP_CYC = 12500
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic en_s,
    output logic      reset_pulse,
    output logic      sleep_go
);

    typedef struct packed {
        logic     en_prev;
        logic     commit;
        frp_cnt_t cnt;
        logic     rst_p;
        logic     sleep;
    } frp_enp_s;

    frp_enp_s st_q;
    frp_enp_s st_d;

    // ======================================================================
    // Once a low period outlasts the reset window the shutdown is committed,
    // even if the pin returns high before the sleep delay is over.
    always_comb begin
        st_d         = st_q;
        st_d.en_prev = en_s;
        st_d.rst_p   = 1'b0;
        if (!en_s || st_q.commit) begin
            if (st_q.cnt != '1) begin
                st_d.cnt = st_q.cnt + 1'b1;
            end
        end else begin
            st_d.cnt = '0;
        end
        if (!en_s && st_q.cnt >= frp_cnt_t'(RST_CYC)) begin
            st_d.commit = 1'b1;
        end
        if (en_s && !st_q.en_prev && !st_q.commit && !st_q.sleep) begin
            st_d.rst_p = 1'b1;
        end
        if (st_q.commit && st_q.cnt >= frp_cnt_t'(SLEEP_CYC)) begin
            st_d.sleep  = 1'b1;
            st_d.commit = 1'b0;
            st_d.cnt    = '0;
        end else if (en_s) begin
            st_d.sleep = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign reset_pulse = st_q.rst_p;
    assign sleep_go    = st_q.sleep;

endmodule // frp_enable_pulse

// >>> frp_fault_ctl.sv
// Fault response and power mode control of a three-phase gate driver.
// Assumes comparator and enable inputs are asynchronous pins and that the
// configuration bits come from register logic on ref_clk.
`timescale 1ns/1ns
`include "frp_defines.svh"

module frp_fault_ctl
#(
    parameter int unsigned RST_CYC   = `FRP_RST_CYC,
    parameter int unsigned SLEEP_CYC = `FRP_SLEEP_CYC,
    parameter int unsigned WAKE_CYC  = `FRP_WAKE_CYC,
    parameter int unsigned RETRY_CYC = `FRP_RETRY_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       enable_pin,
    input  wire logic       die_over_warn,
    input  wire logic       thermal_shutdown_event,
    input  wire logic       motor_supply_undervoltage,
    input  wire logic       drain_sense_undervoltage,
    input  wire logic       charge_pump_undervoltage,
    input  wire logic       low_side_reg_undervoltage,
    input  wire logic       shunt_overcurrent,
    input  wire logic       drain_source_overcurrent,
    input  wire logic       gate_stuck,
    input  wire logic [2:0] pwm_high,
    input  wire logic [2:0] pwm_low,
    input  wire logic       warn_report_enable,
    input  wire logic [1:0] overcurrent_response_select,
    input  wire logic       sense_overcurrent_disable,
    input  wire logic       gate_drive_fault_disable,
    input  wire logic       gate_supply_uv_disable,
    input  wire logic       clear_faults_bit,
    output logic            fault_out_n,
    output logic            global_fault_flag,
    output logic            over_temp_warning_flag,
    output logic            thermal_shutdown_flag,
    output logic            shunt_oc_flag,
    output logic            drain_oc_flag,
    output logic            gate_drive_fault,
    output logic            undervoltage_flag,
    output logic [2:0]      high_gate_out,
    output logic [2:0]      low_gate_out,
    output logic            gate_pull_off,
    output logic            charge_pump_enable,
    output logic            regulators_enable,
    output logic            sense_amp_enable,
    output logic            reg_port_enable,
    output logic            config_defaults,
    output logic            ready_for_inputs
);
    import frp_pkg::*;

    // ======================================================================
    // Synchronised pins
    logic [8:0] pins_s;
    logic       en_s;
    logic       warn_s;
    logic       tsd_s;
    logic       motor_supply_undervoltage_s;
    logic       drain_sense_undervoltage_s;
    logic       cp_uv_s;
    logic       low_side_reg_undervoltage_s;
    logic       sen_oc_s;
    logic       vds_oc_s;
    logic       stuck_s;
    logic       rst_pulse;
    logic       sleep_go;

    frp_pin_sync #(
        .W (9)
    ) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pin_in  ({enable_pin, die_over_warn, thermal_shutdown_event,
                   motor_supply_undervoltage, drain_sense_undervoltage,
                   charge_pump_undervoltage, low_side_reg_undervoltage,
                   shunt_overcurrent, drain_source_overcurrent}),
        .pin_out (pins_s)
    );

    assign {en_s, warn_s, tsd_s, motor_supply_undervoltage_s, drain_sense_undervoltage_s, cp_uv_s, low_side_reg_undervoltage_s,
            sen_oc_s, vds_oc_s} = pins_s;

    // The stuck-gate monitor is timed by the drive logic on this clock.
    assign stuck_s = gate_stuck;

    frp_enable_pulse #(
        .RST_CYC   (RST_CYC),
        .SLEEP_CYC (SLEEP_CYC)
    ) u_enp (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .en_s        (en_s),
        .reset_pulse (rst_pulse),
        .sleep_go    (sleep_go)
    );

    // ======================================================================
    // State
    typedef struct packed {
        frp_mode_e  mode;
        frp_cnt_t   cnt;
        logic       tsd_flag;
        logic       sen_flag;
        logic       vds_flag;
        logic       gdf_flag;
        logic       oc_shut;
        logic       retry_run;
        logic       fault_n;
        logic       glob;
        logic       warn;
        logic       uv;
        logic [2:0] gh;
        logic [2:0] gl;
        logic       pull_off;
        logic       cp_en;
        logic       reg_en;
        logic       sa_en;
        logic       port_en;
        logic       defaults;
        logic       ready;
    } frp_state_s;

    frp_state_s st_q;
    frp_state_s st_d;

    logic clr;
    logic uv_now;
    logic sen_hit;
    logic vds_hit;
    logic oc_hit;
    logic gdf_hit;
    logic warn_rep;
    logic drive_ok;

    always_comb begin
        st_d = st_q;
        // Both clear sources are folded together; the pulse touches flags only.
        clr      = clear_faults_bit | rst_pulse;
        uv_now   = motor_supply_undervoltage_s | drain_sense_undervoltage_s
                 | (!gate_supply_uv_disable & (cp_uv_s | low_side_reg_undervoltage_s));
        sen_hit  = sen_oc_s && !sense_overcurrent_disable
                 && overcurrent_response_select != `FRP_OCR_OFF;
        vds_hit  = vds_oc_s && overcurrent_response_select != `FRP_OCR_OFF;
        oc_hit   = sen_hit | vds_hit;
        gdf_hit  = stuck_s & !gate_drive_fault_disable;
        warn_rep = warn_s & warn_report_enable;

        // Clears apply only once the condition is gone, and a new event wins.
        if (clr && !tsd_s) begin
            st_d.tsd_flag = 1'b0;
        end
        if (tsd_s) begin
            st_d.tsd_flag = 1'b1;
        end
        if (clr && !gdf_hit) begin
            st_d.gdf_flag = 1'b0;
        end
        if (gdf_hit) begin
            st_d.gdf_flag = 1'b1;
        end

        if (clr && !oc_hit && overcurrent_response_select != `FRP_OCR_RETRY) begin
            st_d.sen_flag = 1'b0;
            st_d.vds_flag = 1'b0;
            st_d.oc_shut  = 1'b0;
        end
        if (st_q.retry_run) begin
            if (st_q.cnt >= frp_cnt_t'(RETRY_CYC)) begin
                st_d.retry_run = 1'b0;
                st_d.oc_shut   = 1'b0;
                st_d.sen_flag  = 1'b0;
                st_d.vds_flag  = 1'b0;
            end else begin
                st_d.cnt = st_q.cnt + 1'b1;
            end
        end
        if (oc_hit) begin
            st_d.sen_flag = st_q.sen_flag | sen_hit;
            st_d.vds_flag = st_q.vds_flag | vds_hit;
            unique case (overcurrent_response_select)
                `FRP_OCR_LATCH: begin
                    st_d.oc_shut = 1'b1;
                end
                `FRP_OCR_RETRY: begin
                    st_d.oc_shut   = 1'b1;
                    st_d.retry_run = 1'b1;
                    st_d.cnt       = '0;
                end
                `FRP_OCR_REPORT: begin
                    st_d.oc_shut = st_q.oc_shut;
                end
                `FRP_OCR_OFF: begin
                    st_d.oc_shut = st_q.oc_shut;
                end
            endcase
        end

        // Power modes; the wake counter shares cnt with the retry timer, and both can run while waking.
        unique case (st_q.mode)
            FRP_SLEEP: begin
                if (en_s) begin
                    st_d.mode = FRP_WAKING;
                    st_d.cnt  = '0;
                end
            end
            FRP_WAKING: begin
                if (sleep_go) begin
                    st_d.mode = FRP_SLEEP;
                end else if (st_q.cnt >= frp_cnt_t'(WAKE_CYC)) begin
                    st_d.mode = FRP_ACTIVE;
                end else begin
                    st_d.cnt = st_q.cnt + 1'b1;
                end
            end
            FRP_ACTIVE: begin
                if (sleep_go) begin
                    st_d.mode = FRP_SLEEP;
                end
            end
        endcase

        // Sleep wipes every latched flag back to its default.
        if (st_d.mode == FRP_SLEEP) begin
            st_d.tsd_flag  = 1'b0;
            st_d.sen_flag  = 1'b0;
            st_d.vds_flag  = 1'b0;
            st_d.gdf_flag  = 1'b0;
            st_d.oc_shut   = 1'b0;
            st_d.retry_run = 1'b0;
        end

        // A latched overcurrent or gate-drive fault only stops the bridge; supplies stay up.
        drive_ok = st_q.mode == FRP_ACTIVE && !uv_now && !tsd_s
                 && !st_q.oc_shut && !st_q.gdf_flag;

        st_d.warn     = warn_s;
        st_d.uv       = uv_now;
        st_d.fault_n  = !(uv_now || tsd_s || warn_rep || st_q.sen_flag
                        || st_q.vds_flag || st_q.gdf_flag);
        st_d.glob     = warn_rep || st_q.tsd_flag || st_q.sen_flag
                      || st_q.vds_flag || st_q.gdf_flag || uv_now;
        st_d.gh       = drive_ok ? pwm_high : 3'h0;
        st_d.gl       = drive_ok ? pwm_low : 3'h0;
        st_d.pull_off = st_q.mode == FRP_SLEEP || motor_supply_undervoltage_s || !drive_ok;
        st_d.cp_en    = st_q.mode != FRP_SLEEP && !motor_supply_undervoltage_s && !tsd_s;
        st_d.reg_en   = st_q.mode != FRP_SLEEP && !motor_supply_undervoltage_s;
        st_d.sa_en    = st_q.mode != FRP_SLEEP;
        st_d.port_en  = st_q.mode != FRP_SLEEP && !motor_supply_undervoltage_s;
        st_d.defaults = st_q.mode == FRP_SLEEP;
        st_d.ready    = st_q.mode == FRP_ACTIVE;
    end

    // ======================================================================
    // Reset leaves the device asleep with gates pulled off.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q          <= '0;
            st_q.mode     <= FRP_SLEEP;
            st_q.fault_n  <= 1'b1;
            st_q.pull_off <= 1'b1;
            st_q.defaults <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ======================================================================
    // Outputs
    assign fault_out_n            = st_q.fault_n;
    assign global_fault_flag      = st_q.glob;
    assign over_temp_warning_flag = st_q.warn;
    assign thermal_shutdown_flag  = st_q.tsd_flag;
    assign shunt_oc_flag          = st_q.sen_flag;
    assign drain_oc_flag          = st_q.vds_flag;
    assign gate_drive_fault       = st_q.gdf_flag;
    assign undervoltage_flag      = st_q.uv;
    assign high_gate_out          = st_q.gh;
    assign low_gate_out           = st_q.gl;
    assign gate_pull_off          = st_q.pull_off;
    assign charge_pump_enable     = st_q.cp_en;
    assign regulators_enable      = st_q.reg_en;
    assign sense_amp_enable       = st_q.sa_en;
    assign reg_port_enable        = st_q.port_en;
    assign config_defaults        = st_q.defaults;
    assign ready_for_inputs       = st_q.ready;

endmodule // frp_fault_ctl

// >>> frp_fault_ctl_asserts.sv
// Concurrent checks on the ports of the fault response block.
// Assumes it is bound onto frp_fault_ctl and shares its counts.
`timescale 1ns/1ns

module frp_fault_ctl_asserts #(
    parameter int unsigned SLEEP_CYC = 12500,
    parameter int unsigned RETRY_CYC = 500000
) (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       enable_pin,
    input wire logic       die_over_warn,
    input wire logic       thermal_shutdown_event,
    input wire logic       shunt_overcurrent,
    input wire logic [1:0] overcurrent_response_select,
    input wire logic       sense_overcurrent_disable,
    input wire logic       warn_report_enable,
    input wire logic       clear_faults_bit,
    input wire logic       fault_out_n,
    input wire logic       global_fault_flag,
    input wire logic       over_temp_warning_flag,
    input wire logic       thermal_shutdown_flag,
    input wire logic       shunt_oc_flag,
    input wire logic [2:0] high_gate_out,
    input wire logic [2:0] low_gate_out,
    input wire logic       gate_pull_off,
    input wire logic       charge_pump_enable,
    input wire logic       config_defaults,
    input wire logic       ready_for_inputs
);
    logic [23:0] low_cnt_q;
    logic [23:0] oc_cnt_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // ======================================================================
    // Helper counters
    // Counters saturate so a long sleep cannot wrap into a false hit.
    always_ff @(posedge ref_clk) begin
        if (rst || enable_pin) low_cnt_q <= '0;
        else if (low_cnt_q != '1) low_cnt_q <= low_cnt_q + 24'h1;
    end
    always_ff @(posedge ref_clk) begin
        if (rst || shunt_overcurrent || !shunt_oc_flag || overcurrent_response_select != 2'h1)
            oc_cnt_q <= '0;
        else if (oc_cnt_q != '1) oc_cnt_q <= oc_cnt_q + 24'h1;
    end

    // ======================================================================
    // Sequences and assertions
    sequence s_hot;
        (thermal_shutdown_event && ready_for_inputs)[*8];
    endsequence
    sequence s_latched;
        (shunt_oc_flag && overcurrent_response_select == 2'h0 && !clear_faults_bit
         && enable_pin)[*8];
    endsequence

    sd_latch_a: assert property (s_hot |-> thermal_shutdown_flag && !fault_out_n
        && !charge_pump_enable && high_gate_out == 3'h0) else $error("shutdown not taken");
    warn_set_a: assert property ((die_over_warn && ready_for_inputs)[*8]
        |-> over_temp_warning_flag) else $error("warning flag not set");
    warn_clear_a: assert property ((!die_over_warn)[*8] |-> !over_temp_warning_flag)
        else $error("warning flag stuck");
    warn_rep_a: assert property ((over_temp_warning_flag && warn_report_enable)[*3]
        |-> global_fault_flag && !fault_out_n) else $error("warning not reported");
    sense_off_a: assert property ($rose(shunt_oc_flag) |-> !sense_overcurrent_disable
        && overcurrent_response_select != 2'h3) else $error("disabled overcurrent flagged");
    latch_hold_a: assert property (s_latched |=> shunt_oc_flag && !fault_out_n
        && high_gate_out == 3'h0 && low_gate_out == 3'h0) else $error("latched fault lost");
    retry_len_a: assert property (oc_cnt_q <= 24'(RETRY_CYC + 8))
        else $error("retry too long");
    sleep_gate_a: assert property (config_defaults |-> gate_pull_off
        && high_gate_out == 3'h0 && low_gate_out == 3'h0) else $error("gates live asleep");
    sleep_wait_a: assert property ($fell(enable_pin) && ready_for_inputs
        |=> (!config_defaults)[*8]) else $error("sleep too early");
    sleep_entry_a: assert property (low_cnt_q == 24'(SLEEP_CYC + 8) |-> config_defaults)
        else $error("sleep not entered");
endmodule // frp_fault_ctl_asserts

bind frp_fault_ctl frp_fault_ctl_asserts #(.SLEEP_CYC(SLEEP_CYC), .RETRY_CYC(RETRY_CYC))
    u_asserts (.ref_clk, .rst, .enable_pin, .die_over_warn, .thermal_shutdown_event,
    .shunt_overcurrent,
    .overcurrent_response_select, .sense_overcurrent_disable, .warn_report_enable,
    .clear_faults_bit, .fault_out_n, .global_fault_flag, .over_temp_warning_flag,
    .thermal_shutdown_flag, .shunt_oc_flag, .high_gate_out, .low_gate_out, .gate_pull_off,
    .charge_pump_enable, .config_defaults, .ready_for_inputs);

// >>> frp_ctrl_model.sv
// Model of the motor controller driving enable and the clear bit.
// Assumes req is held until done rises; kind 0 wake, 1 sleep, 2 pulse, 3 clear.
`timescale 1ns/1ns

module frp_ctrl_model #(
    parameter int RST_CYC = 10
) (
    input  wire logic       ref_clk,
    input  wire logic       req,
    input  wire logic [1:0] kind,
    output logic            enable_pin,
    output logic            clear_faults_bit,
    output logic            done
);
    logic req_s;

    // Request is sampled on the edge so it never races the bench's own updates.
    initial begin
        enable_pin = 1'b0;
        clear_faults_bit = 1'b0;
        done = 1'b0;
        forever begin
            @(posedge ref_clk);
            req_s = req;
            #1;
            if (!req_s) done = 1'b0;
            else if (!done) begin
                case (kind)
                    2'h0: enable_pin = 1'b1;
                    2'h1: enable_pin = 1'b0;
                    2'h2: begin
                        // Half the window keeps the pulse clear of sleep.
                        enable_pin = 1'b0;
                        repeat (RST_CYC / 2) @(posedge ref_clk);
                        #1 enable_pin = 1'b1;
                    end
                    default: begin
                        clear_faults_bit = 1'b1;
                        @(posedge ref_clk);
                        #1 clear_faults_bit = 1'b0;
                    end
                endcase
                done = 1'b1;
            end
        end
    end
endmodule // frp_ctrl_model

// >>> testbench.sv
// Self-checking bench for the fault response and power mode block.
// Assumes short counts; the controller model drives enable and clear.
`timescale 1ns/1ns

module testbench;
    localparam int RST_C = 10;
    localparam int SLP_C = 40;
    localparam int WK_C  = 20;
    localparam int RTY_C = 50;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic die_over_warn, thermal_shutdown_event, shunt_overcurrent, gate_stuck;
    logic warn_report_enable, sense_overcurrent_disable, gate_drive_fault_disable;
    logic gate_supply_uv_disable, enable_pin, clear_faults_bit, req, done;
    logic [3:0] uv;
    logic [2:0] pwm_high, pwm_low, high_gate_out, low_gate_out;
    logic [1:0] overcurrent_response_select, kind;
    logic fault_out_n, global_fault_flag, over_temp_warning_flag, thermal_shutdown_flag;
    logic shunt_oc_flag, drain_oc_flag, gate_drive_fault, undervoltage_flag, gate_pull_off;
    logic charge_pump_enable, regulators_enable, sense_amp_enable, reg_port_enable;
    logic config_defaults, ready_for_inputs;
    int errors = 0;
    int n_checks = 0;
    int t;

    always #4 ref_clk = ~ref_clk;

    frp_ctrl_model #(.RST_CYC(RST_C)) ctl (.ref_clk, .req, .kind, .enable_pin,
        .clear_faults_bit, .done);

    frp_fault_ctl #(.RST_CYC(RST_C), .SLEEP_CYC(SLP_C), .WAKE_CYC(WK_C), .RETRY_CYC(RTY_C))
    dut (.ref_clk, .rst, .enable_pin, .die_over_warn, .thermal_shutdown_event,
        .motor_supply_undervoltage(uv[0]), .drain_sense_undervoltage(uv[1]),
        .charge_pump_undervoltage(uv[2]), .low_side_reg_undervoltage(uv[3]),
        .shunt_overcurrent, .drain_source_overcurrent(1'b0), .gate_stuck, .pwm_high, .pwm_low,
        .warn_report_enable, .overcurrent_response_select, .sense_overcurrent_disable,
        .gate_drive_fault_disable, .gate_supply_uv_disable, .clear_faults_bit, .fault_out_n,
        .global_fault_flag, .over_temp_warning_flag, .thermal_shutdown_flag, .shunt_oc_flag,
        .drain_oc_flag, .gate_drive_fault, .undervoltage_flag, .high_gate_out, .low_gate_out,
        .gate_pull_off, .charge_pump_enable, .regulators_enable, .sense_amp_enable,
        .reg_port_enable, .config_defaults, .ready_for_inputs);

    // ======================================================================
    // Tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic close_out;
        if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Requests stay up until the model answers, so none is lost.
    task automatic ctl_do(input logic [1:0] k);
        int i;
        i = 0;
        req = 1'b1;
        kind = k;
        do begin
            @(posedge ref_clk);
            i++;
        end while (done !== 1'b1 && i < 200);
        #1;
        if (done !== 1'b1) begin
            errors++;
            close_out();
        end
        req = 1'b0;
        cyc(1);
    endtask

    // ======================================================================
    // Main sequence
    initial begin
        {die_over_warn, thermal_shutdown_event, shunt_overcurrent, gate_stuck, uv} = '0;
        {warn_report_enable, sense_overcurrent_disable, gate_drive_fault_disable} = '0;
        {gate_supply_uv_disable, req, kind, overcurrent_response_select} = '0;
        pwm_high = 3'h5;
        pwm_low = 3'h2;
        repeat (16) @(posedge ref_clk);
        #1 rst = 1'b0;
        chk({fault_out_n, config_defaults, gate_pull_off, ready_for_inputs}, 8'h0e);
        ctl_do(2'h0);
        for (t = 0; ready_for_inputs !== 1'b1 && t < 200; t++) cyc(1);
        chk({7'h0, t >= WK_C && t <= WK_C + 10}, 8'h01);
        chk({charge_pump_enable, regulators_enable, reg_port_enable, config_defaults}, 8'h0e);
        cyc(2);
        die_over_warn = 1'b1;
        cyc(10);
        chk({over_temp_warning_flag, fault_out_n, global_fault_flag, 2'h0, high_gate_out}, 8'hc5);
        warn_report_enable = 1'b1;
        cyc(4);
        chk({6'h0, global_fault_flag, fault_out_n}, 8'h02);
        die_over_warn = 1'b0;
        cyc(10);
        chk({5'h0, over_temp_warning_flag, global_fault_flag, fault_out_n}, 8'h01);
        warn_report_enable = 1'b0;
        thermal_shutdown_event = 1'b1;
        cyc(10);
        chk({thermal_shutdown_flag, fault_out_n, charge_pump_enable, 2'h0, high_gate_out}, 8'h80);
        thermal_shutdown_event = 1'b0;
        cyc(10);
        chk({thermal_shutdown_flag, fault_out_n, charge_pump_enable, 2'h0, high_gate_out}, 8'he5);
        ctl_do(2'h3);
        cyc(3);
        chk({6'h0, thermal_shutdown_flag, global_fault_flag}, 8'h00);
        for (int m = 0; m < 4; m++) begin
            overcurrent_response_select = m[1:0];
            shunt_overcurrent = 1'b1;
            cyc(10);
            chk({shunt_oc_flag, fault_out_n, 3'h0, high_gate_out},
                {m != 3, m == 3, 3'h0, (m < 2) ? 3'h0 : 3'h5});
            shunt_overcurrent = 1'b0;
            cyc(10);
            chk({shunt_oc_flag, fault_out_n, 3'h0, high_gate_out},
                {m != 3, m == 3, 3'h0, (m < 2) ? 3'h0 : 3'h5});
            if (m == 0) begin
                ctl_do(2'h2);
                cyc(8);
                chk({5'h0, config_defaults, ready_for_inputs, regulators_enable}, 8'h03);
            end
            if (m == 1) cyc(RTY_C);
            if (m == 2) ctl_do(2'h3);
            cyc(3);
            chk({shunt_oc_flag, fault_out_n, 3'h0, high_gate_out}, 8'h45);
        end
        overcurrent_response_select = 2'h0;
        sense_overcurrent_disable = 1'b1;
        shunt_overcurrent = 1'b1;
        cyc(10);
        chk({shunt_oc_flag, fault_out_n, 3'h0, high_gate_out}, 8'h45);
        {shunt_overcurrent, sense_overcurrent_disable} = 2'h0;
        for (int g = 0; g < 2; g++) begin
            gate_drive_fault_disable = g[0];
            gate_stuck = 1'b1;
            cyc(3);
            gate_stuck = 1'b0;
            cyc(6);
            chk({gate_drive_fault, fault_out_n, 3'h0, high_gate_out}, g ? 8'h45 : 8'h80);
            ctl_do(2'h3);
            cyc(3);
            chk({gate_drive_fault, fault_out_n, 3'h0, high_gate_out}, 8'h45);
        end
        for (int u = 0; u < 6; u++) begin
            gate_supply_uv_disable = (u > 3);
            uv[(u > 3) ? u - 2 : u] = 1'b1;
            cyc(10);
            chk({fault_out_n, gate_pull_off, 6'h0}, (u > 3) ? 8'h80 : 8'h40);
            uv = 4'h0;
            cyc(40);
            chk({undervoltage_flag, fault_out_n, gate_pull_off, 2'h0, high_gate_out}, 8'h45);
        end
        ctl_do(2'h1);
        cyc(8);
        chk({7'h0, config_defaults}, 8'h00);
        cyc(SLP_C + 8);
        chk({config_defaults, gate_pull_off, reg_port_enable, charge_pump_enable,
             sense_amp_enable, 3'h0}, 8'hc0);
        close_out();
    end

    // A hang ends the run through the same closing report.
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        $display("mismatch at %0t: run did not finish", $time);
        close_out();
    end
endmodule // testbench
